//--- bench/mhf_host_model.sv
// Host computer model: collects host-bound bytes and resolves the wake line
`default_nettype none
module mhf_host_model (
   input wire logic clk_i,
   input wire logic host_valid_i,
   input wire logic [7:0] host_data_i,
   input wire logic pme_out_i,
   input wire logic pme_oe_n_i,
   output logic pme_line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx_q[$];
   // Pulled-up line, so a released line reads high
   assign pme_line_o = pme_oe_n_i ? 1'b1 : pme_out_i;
   // No back-pressure on this path, so every valid byte is taken
   always @(posedge clk_i) begin
      if (host_valid_i === 1'b1) begin
         rx_q.push_back(host_data_i);
      end
   end
endmodule
`default_nettype wire

//--- bench/test_modem_host_frame_forwarder.sv
// Testbench for the modem host frame forwarder
`default_nettype none
module test_modem_host_frame_forwarder;
   timeunit 1ns;
   timeprecision 1ns;
   import mhf_pkg::*;
   localparam logic [47:0] HA = 48'h0200_1122_3344;
   localparam logic [47:0] MA = 48'h0200_5566_7788;
   localparam logic [47:0] OA = 48'h0200_99AA_BBCC;
   localparam logic [47:0] M1 = 48'h0100_5E00_0001;
   localparam logic [47:0] M2 = 48'h0100_5E00_0002;
   logic clk_i, rst_n_i, cfg_load_i, cfg_up_en_i, opf_we_i, opf_valid_i, dn_valid_i, dn_sof_i, dn_eof_i;
   logic up_valid_i, up_sof_i, up_eof_i, up_pdu_i, cab_ready_i, cmd_valid_i, pme_line, r_err;
   logic dn_ready_o, host_valid_o, host_sof_o, host_eof_o, host_abort_o, stk_valid_o, stk_sof_o, stk_eof_o;
   logic stk_abort_o, up_ready_o, cab_valid_o, cab_sof_o, cab_eof_o, cab_abort_o, resp_valid_o, resp_err_o;
   logic pme_out_o, pme_oe_n_o, frm_err_o;
   logic [47:0] cfg_modem_addr_i, cfg_host_addr_i, opf_addr_i, cmd_data_i, resp_data_o;
   logic [7:0] dn_data_i, up_data_i, host_data_o, stk_data_o, cab_data_o;
   logic [1:0] opf_idx_i, cmd_idx_i;
   logic [2:0] cmd_op_i;
   int n_fail = 0;
   int cmp_count = 0;
   int n_stk = 0;
   int n_cab = 0;
   int n_se = 0;
   logic stall_up = 1'b0;
   initial clk_i = 1'b0;
   always #25 clk_i = ~clk_i;
   initial begin
      {rst_n_i, cfg_load_i, cfg_up_en_i, opf_we_i, opf_valid_i, dn_valid_i, dn_sof_i, dn_eof_i} = '0;
      {up_valid_i, up_sof_i, up_eof_i, up_pdu_i, cmd_valid_i, cfg_modem_addr_i, cfg_host_addr_i} = '0;
      {opf_addr_i, cmd_data_i, dn_data_i, up_data_i, opf_idx_i, cmd_idx_i, cmd_op_i} = '0;
      cab_ready_i = 1'b1;
   end
   mhf_forwarder #(.FILT_N(4)) u_dut (.clk_i, .rst_n_i, .cfg_load_i, .cfg_modem_addr_i, .cfg_host_addr_i,
      .cfg_up_en_i, .opf_we_i, .opf_idx_i, .opf_addr_i, .opf_valid_i, .dn_valid_i, .dn_data_i, .dn_sof_i,
      .dn_eof_i, .dn_ready_o, .host_valid_o, .host_data_o, .host_sof_o, .host_eof_o, .host_abort_o,
      .stk_valid_o, .stk_data_o, .stk_sof_o, .stk_eof_o, .stk_abort_o, .up_valid_i, .up_data_i, .up_sof_i,
      .up_eof_i, .up_pdu_i, .up_ready_o, .cab_valid_o, .cab_data_o, .cab_sof_o, .cab_eof_o, .cab_abort_o,
      .cab_ready_i, .cmd_valid_i, .cmd_op_i, .cmd_idx_i, .cmd_data_i, .resp_valid_o, .resp_data_o,
      .resp_err_o, .pme_in_i(pme_line), .pme_out_o, .pme_oe_n_o, .frm_err_o);
   mhf_host_model u_host (.clk_i, .host_valid_i(host_valid_o), .host_data_i(host_data_o),
      .pme_out_i(pme_out_o), .pme_oe_n_i(pme_oe_n_o), .pme_line_o(pme_line));
   always @(posedge clk_i) begin
      if (stk_valid_o === 1'b1)
         n_stk++;
      if (cab_valid_o === 1'b1 && cab_ready_i === 1'b1)
         n_cab++;
      if (host_sof_o === 1'b1)
         n_se++;
      if (host_eof_o === 1'b1)
         n_se++;
      if (stk_sof_o === 1'b1)
         n_se++;
      if (stk_eof_o === 1'b1)
         n_se++;
   end
   // Cable side stalls every other cycle when asked
   always @(posedge clk_i)
      cab_ready_i <= !stall_up || !cab_ready_i;
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Eight-byte frame: six address bytes then two payload bytes
   task automatic t_dn(input logic [47:0] d, input logic h, input logic s);
      u_host.rx_q.delete();
      n_stk = 0;
      n_se = 0;
      for (int i = 0; i < 8; i++) begin
         dn_valid_i <= 1'b1;
         dn_data_i <= (i < 6) ? d[47-8*i -: 8] : 8'hE3;
         dn_sof_i <= (i == 0);
         dn_eof_i <= (i == 7);
         do @(negedge clk_i); while (dn_ready_o !== 1'b1);
         @(posedge clk_i);
      end
      dn_valid_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(48'(u_host.rx_q.size()), h ? 48'h8 : 48'h0);
      chk(48'(n_stk), s ? 48'h8 : 48'h0);
      chk(48'(n_se), {46'h0, h, 1'b0} + {46'h0, s, 1'b0});
      if (h)
         chk({u_host.rx_q[0], u_host.rx_q[1], u_host.rx_q[2], u_host.rx_q[3], u_host.rx_q[4], u_host.rx_q[5]}, d);
   endtask
   task automatic t_cmd(input logic [2:0] op, input logic [47:0] d);
      cmd_valid_i <= 1'b1;
      cmd_op_i <= op;
      cmd_data_i <= d;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      @(negedge clk_i);
      chk(resp_valid_o, 1'b1);
      r_err = resp_err_o;
      @(posedge clk_i);
   endtask
   task automatic t_up(input logic pdu, input int exp, input logic st);
      n_cab = 0;
      stall_up <= st;
      for (int i = 0; i < 4; i++) begin
         up_valid_i <= 1'b1;
         up_data_i <= 8'(8'hA0 + i);
         up_sof_i <= (i == 0);
         up_eof_i <= (i == 3);
         up_pdu_i <= pdu;
         do @(negedge clk_i); while (up_ready_o !== 1'b1);
         @(posedge clk_i);
      end
      up_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(48'(n_cab), 48'(exp));
   endtask
   task automatic t_stray();
      dn_valid_i <= 1'b1;
      dn_sof_i <= 1'b0;
      @(posedge clk_i);
      dn_valid_i <= 1'b0;
      @(negedge clk_i);
      chk(frm_err_o, 1'b1);
      @(posedge clk_i);
   endtask
   // Start mark inside a host frame body aborts it
   task automatic t_abort();
      for (int i = 0; i < 9; i++) begin
         dn_valid_i <= 1'b1;
         dn_data_i <= (i < 6) ? HA[47-8*i -: 8] : 8'hE3;
         dn_sof_i <= (i == 0 || i == 7);
         dn_eof_i <= (i == 8);
         do @(negedge clk_i); while (dn_ready_o !== 1'b1);
         if (i == 8)
            chk({host_abort_o, stk_abort_o, frm_err_o}, 3'b101);
         @(posedge clk_i);
      end
      dn_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      cfg_load_i <= 1'b1;
      cfg_modem_addr_i <= MA;
      cfg_host_addr_i <= HA;
      cfg_up_en_i <= 1'b1;
      opf_we_i <= 1'b1;
      opf_addr_i <= M1;
      opf_valid_i <= 1'b1;
      @(posedge clk_i);
      cfg_load_i <= 1'b0;
      opf_we_i <= 1'b0;
      @(posedge clk_i);
      t_dn(HA, 1'b1, 1'b0);
      t_dn(OA, 1'b0, 1'b0);
      t_dn(MA, 1'b0, 1'b1);
      t_dn(BCAST_ADDR, 1'b1, 1'b1);
      t_dn(M1, 1'b1, 1'b0);
      t_dn(M2, 1'b0, 1'b0);
      t_cmd(CMD_MC_EN, 48'h1);
      t_dn(M1, 1'b0, 1'b0);
      t_cmd(CMD_SET_MC, M1);
      t_dn(M1, 1'b1, 1'b0);
      t_cmd(CMD_RD_HOST, 48'h0);
      chk(resp_data_o, HA);
      t_cmd(3'h7, 48'h0);
      chk(r_err, 1'b1);
      t_cmd(CMD_SET_WAKE, {8'h00, 8'h02, HA[31:0]});
      t_cmd(CMD_RD_WAKE, 48'h0);
      chk(resp_data_o, {8'h00, 8'h02, HA[31:0]});
      t_cmd(CMD_SLEEP, 48'h1);
      t_dn(OA, 1'b0, 1'b0);
      chk(pme_line, 1'b1);
      t_dn(HA, 1'b1, 1'b0);
      chk(pme_line, 1'b0);
      t_cmd(CMD_SLEEP, 48'h0);
      repeat (2) @(posedge clk_i);
      chk(pme_oe_n_o, 1'b1);
      t_up(1'b1, 4, 1'b1);
      t_up(1'b0, 0, 1'b0);
      t_stray();
      t_abort();
      summarize();
   end
endmodule
`default_nettype wire

//--- hdl/mhf_addr_filter.sv
// Destination address classifier and forwarding decision
`default_nettype none
module mhf_addr_filter #(
   parameter int FILT_N = mhf_pkg::FILT_N_DEF
) (
   input wire logic [mhf_pkg::ADDR_W-1:0] dest_i,
   input wire logic [mhf_pkg::ADDR_W-1:0] host_addr_i,
   input wire logic [mhf_pkg::ADDR_W-1:0] modem_addr_i,
   input wire logic [FILT_N*mhf_pkg::ADDR_W-1:0] op_tab_i,
   input wire logic [FILT_N-1:0] op_vld_i,
   input wire logic [FILT_N*mhf_pkg::ADDR_W-1:0] hm_tab_i,
   input wire logic [FILT_N-1:0] hm_vld_i,
   input wire logic hm_en_i,
   output logic to_host_o,
   output logic to_stack_o
);
   import mhf_pkg::*;

   logic is_bc;
   logic is_mc;
   logic is_uc;
   logic mc_ok;

   function automatic logic tab_hit(input logic [FILT_N*ADDR_W-1:0] tab, input logic [FILT_N-1:0] vld,
                                    input logic [ADDR_W-1:0] a);
      logic h;
      h = 1'b0;
      for (int i = 0; i < FILT_N; i++) begin
         if (vld[i] && tab[i*ADDR_W +: ADDR_W] == a) begin
            h = 1'b1;
         end
      end
      return h;
   endfunction

   always_comb begin
      is_bc = (dest_i == BCAST_ADDR); // R21
      is_mc = dest_i[GROUP_BIT] && !is_bc; // R21
      is_uc = !dest_i[GROUP_BIT]; // R21
      // Host list can only narrow the operator list, never widen it
      mc_ok = tab_hit(op_tab_i, op_vld_i, dest_i) && (!hm_en_i || tab_hit(hm_tab_i, hm_vld_i, dest_i)); // R8 R9
      // Known-address forwarding only; no learning, no spanning tree, no forward-all path
      to_stack_o = (is_uc && dest_i == modem_addr_i) || is_bc; // R5 R18
      to_host_o = (is_uc && dest_i == host_addr_i && dest_i != modem_addr_i) // R3 R4 R6 R20
                  || is_bc // R7
                  || (is_mc && mc_ok); // R8
   end
endmodule
`default_nettype wire

//--- hdl/mhf_forwarder.sv
// Modem host frame forwarder: downstream filter, upstream path, management, wake
`default_nettype none
module mhf_forwarder #(
   parameter int FILT_N = mhf_pkg::FILT_N_DEF,
   parameter int IDX_W = (FILT_N > 1) ? $clog2(FILT_N) : 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cfg_load_i,
   input wire logic [mhf_pkg::ADDR_W-1:0] cfg_modem_addr_i,
   input wire logic [mhf_pkg::ADDR_W-1:0] cfg_host_addr_i,
   input wire logic cfg_up_en_i,
   input wire logic opf_we_i,
   input wire logic [IDX_W-1:0] opf_idx_i,
   input wire logic [mhf_pkg::ADDR_W-1:0] opf_addr_i,
   input wire logic opf_valid_i,
   input wire logic dn_valid_i,
   input wire logic [7:0] dn_data_i,
   input wire logic dn_sof_i,
   input wire logic dn_eof_i,
   output logic dn_ready_o,
   output logic host_valid_o,
   output logic [7:0] host_data_o,
   output logic host_sof_o,
   output logic host_eof_o,
   output logic host_abort_o,
   output logic stk_valid_o,
   output logic [7:0] stk_data_o,
   output logic stk_sof_o,
   output logic stk_eof_o,
   output logic stk_abort_o,
   input wire logic up_valid_i,
   input wire logic [7:0] up_data_i,
   input wire logic up_sof_i,
   input wire logic up_eof_i,
   input wire logic up_pdu_i,
   output logic up_ready_o,
   output logic cab_valid_o,
   output logic [7:0] cab_data_o,
   output logic cab_sof_o,
   output logic cab_eof_o,
   output logic cab_abort_o,
   input wire logic cab_ready_i,
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_op_i,
   input wire logic [IDX_W-1:0] cmd_idx_i,
   input wire logic [mhf_pkg::ADDR_W-1:0] cmd_data_i,
   output logic resp_valid_o,
   output logic [mhf_pkg::ADDR_W-1:0] resp_data_o,
   output logic resp_err_o,
   input wire logic pme_in_i,
   output logic pme_out_o,
   output logic pme_oe_n_o,
   output logic frm_err_o
);
   import mhf_pkg::*;

   // Management and configuration state
   logic [ADDR_W-1:0] modem_reg, modem_next;
   logic [ADDR_W-1:0] host_reg, host_next;
   logic up_en_reg, up_en_next;
   logic [FILT_N*ADDR_W-1:0] op_tab_reg, op_tab_next;
   logic [FILT_N-1:0] op_vld_reg, op_vld_next;
   logic [FILT_N*ADDR_W-1:0] hm_tab_reg, hm_tab_next;
   logic [FILT_N-1:0] hm_vld_reg, hm_vld_next;
   logic hm_en_reg, hm_en_next;
   logic sleep_reg, sleep_next;
   logic [31:0] wk_pat_reg, wk_pat_next;
   logic [7:0] wk_off_reg, wk_off_next;
   logic resp_vld_reg, resp_vld_next;
   logic resp_err_reg, resp_err_next;
   logic [ADDR_W-1:0] resp_data_reg, resp_data_next;

   always_comb begin
      modem_next = modem_reg;
      host_next = host_reg;
      up_en_next = up_en_reg;
      op_tab_next = op_tab_reg;
      op_vld_next = op_vld_reg;
      hm_tab_next = hm_tab_reg;
      hm_vld_next = hm_vld_reg;
      hm_en_next = hm_en_reg;
      sleep_next = sleep_reg;
      wk_pat_next = wk_pat_reg;
      wk_off_next = wk_off_reg;
      resp_vld_next = 1'b0;
      resp_err_next = 1'b0;
      resp_data_next = resp_data_reg;
      if (cfg_load_i) begin
         modem_next = cfg_modem_addr_i; // R2
         host_next = cfg_host_addr_i; // R2
         up_en_next = cfg_up_en_i;
      end
      // Operator list has its own port; no command below touches or returns it
      if (opf_we_i) begin
         op_tab_next[opf_idx_i*ADDR_W +: ADDR_W] = opf_addr_i; // R10
         op_vld_next[opf_idx_i] = opf_valid_i; // R10
      end
      if (cmd_valid_i) begin
         resp_vld_next = 1'b1; // R15
         case (cmd_op_i)
            CMD_RD_HOST: begin
               resp_data_next = host_reg; // R16
            end
            CMD_SET_MC: begin
               hm_tab_next[cmd_idx_i*ADDR_W +: ADDR_W] = cmd_data_i; // R9
               hm_vld_next[cmd_idx_i] = 1'b1; // R9
            end
            CMD_CLR_MC: begin
               hm_vld_next[cmd_idx_i] = 1'b0; // R9
            end
            CMD_MC_EN: begin
               hm_en_next = cmd_data_i[0]; // R9
            end
            CMD_SET_WAKE: begin
               wk_pat_next = cmd_data_i[31:0]; // R17
               wk_off_next = cmd_data_i[39:32]; // R17
            end
            CMD_RD_WAKE: begin
               resp_data_next = {WK_PAD, wk_off_reg, wk_pat_reg}; // R17
            end
            CMD_SLEEP: begin
               sleep_next = cmd_data_i[0]; // R12
            end
            default: begin
               resp_err_next = 1'b1; // R15
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         modem_reg <= ADDR_RST;
         host_reg <= ADDR_RST;
         up_en_reg <= 1'b0;
         op_tab_reg <= '0;
         op_vld_reg <= '0;
         hm_tab_reg <= '0;
         hm_vld_reg <= '0;
         hm_en_reg <= 1'b0;
         sleep_reg <= 1'b0;
         wk_pat_reg <= WK_PAT_RST;
         wk_off_reg <= WK_OFF_RST;
         resp_vld_reg <= 1'b0;
         resp_err_reg <= 1'b0;
         resp_data_reg <= ADDR_RST;
      end else begin
         modem_reg <= modem_next;
         host_reg <= host_next;
         up_en_reg <= up_en_next;
         op_tab_reg <= op_tab_next;
         op_vld_reg <= op_vld_next;
         hm_tab_reg <= hm_tab_next;
         hm_vld_reg <= hm_vld_next;
         hm_en_reg <= hm_en_next;
         sleep_reg <= sleep_next;
         wk_pat_reg <= wk_pat_next;
         wk_off_reg <= wk_off_next;
         resp_vld_reg <= resp_vld_next;
         resp_err_reg <= resp_err_next;
         resp_data_reg <= resp_data_next;
      end
   end

   // Downstream path: six address bytes held, then replayed once the verdict is known
   mhf_state_e state_reg, state_next;
   logic [ADDR_W-1:0] hdr_reg, hdr_next;
   logic [2:0] hidx_reg, hidx_next;
   logic [2:0] eidx_reg, eidx_next;
   logic to_host_reg, to_host_next;
   logic to_stk_reg, to_stk_next;
   logic [7:0] od_reg, od_next;
   logic hv_reg, hv_next;
   logic sv_reg, sv_next;
   logic osof_reg, osof_next;
   logic oeof_reg, oeof_next;
   logic habt_reg, habt_next;
   logic sabt_reg, sabt_next;
   logic [31:0] win_reg, win_next;
   logic [7:0] pos_reg, pos_next;
   logic wake_reg, wake_next;
   logic flt_host;
   logic flt_stk;
   logic dn_acc;
   logic dn_err;

   mhf_addr_filter #(.FILT_N(FILT_N)) u_filter (
      .dest_i(hdr_next),
      .host_addr_i(host_reg),
      .modem_addr_i(modem_reg),
      .op_tab_i(op_tab_reg),
      .op_vld_i(op_vld_reg),
      .hm_tab_i(hm_tab_reg),
      .hm_vld_i(hm_vld_reg),
      .hm_en_i(hm_en_reg),
      .to_host_o(flt_host),
      .to_stack_o(flt_stk)
   );

   assign dn_ready_o = (state_reg != ST_EMIT);
   assign dn_acc = dn_valid_i && dn_ready_o;

   always_comb begin
      state_next = state_reg;
      hdr_next = hdr_reg;
      hidx_next = hidx_reg;
      eidx_next = eidx_reg;
      to_host_next = to_host_reg;
      to_stk_next = to_stk_reg;
      od_next = od_reg;
      hv_next = 1'b0;
      sv_next = 1'b0;
      osof_next = 1'b0;
      oeof_next = 1'b0;
      habt_next = 1'b0;
      sabt_next = 1'b0;
      dn_err = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (dn_acc && !dn_sof_i) begin
               dn_err = 1'b1; // R14
            end
         end
         ST_HDR: begin
            if (dn_acc && !dn_sof_i) begin
               hdr_next[47-8*hidx_reg -: 8] = dn_data_i; // R1
               if (dn_eof_i) begin
                  state_next = ST_IDLE; // R14
               end else if (hidx_reg == HDR_LAST) begin
                  eidx_next = 3'h0;
                  to_host_next = flt_host;
                  to_stk_next = flt_stk;
                  state_next = (flt_host || flt_stk) ? ST_EMIT : ST_DROP; // R4 R20
               end else begin
                  hidx_next = hidx_reg + 3'h1;
               end
            end
         end
         ST_EMIT: begin
            od_next = hdr_reg[47-8*eidx_reg -: 8]; // R19
            hv_next = to_host_reg; // R3
            sv_next = to_stk_reg; // R5
            osof_next = (eidx_reg == 3'h0); // R14
            if (eidx_reg == HDR_LAST) begin
               state_next = ST_BODY;
            end else begin
               eidx_next = eidx_reg + 3'h1;
            end
         end
         ST_BODY: begin
            if (dn_acc && dn_sof_i) begin
               habt_next = to_host_reg; // R14
               sabt_next = to_stk_reg; // R14
            end else if (dn_acc) begin
               // Payload, LLC TEST/XID included, goes through untouched and unanswered
               od_next = dn_data_i; // R11 R19
               hv_next = to_host_reg; // R11
               sv_next = to_stk_reg;
               oeof_next = dn_eof_i; // R14
               if (dn_eof_i) begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_DROP: begin
            if (dn_acc && !dn_sof_i && dn_eof_i) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // A start mark always resynchronises, even mid-frame
      if (dn_acc && dn_sof_i) begin
         hdr_next[47:40] = dn_data_i; // R14
         hidx_next = 3'h1;
         state_next = dn_eof_i ? ST_IDLE : ST_HDR; // R14
         if (state_reg != ST_IDLE) begin
            dn_err = 1'b1; // R14
         end
      end
      win_next = win_reg;
      pos_next = pos_reg;
      wake_next = wake_reg;
      if (hv_next) begin
         win_next = {win_reg[23:0], od_next};
         pos_next = osof_next ? 8'h00 : ((pos_reg == POS_MAX) ? POS_MAX : pos_reg + 8'h01);
         if (sleep_reg && win_next == wk_pat_reg && pos_next == wk_off_reg + WK_SPAN) begin
            wake_next = 1'b1; // R12
         end
      end
      // Wake latch holds until the host leaves sleep
      if (!sleep_reg) begin
         wake_next = 1'b0; // R12
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         hdr_reg <= ADDR_RST;
         hidx_reg <= 3'h0;
         eidx_reg <= 3'h0;
         to_host_reg <= 1'b0;
         to_stk_reg <= 1'b0;
         od_reg <= 8'h00;
         hv_reg <= 1'b0;
         sv_reg <= 1'b0;
         osof_reg <= 1'b0;
         oeof_reg <= 1'b0;
         habt_reg <= 1'b0;
         sabt_reg <= 1'b0;
         win_reg <= WK_PAT_RST;
         pos_reg <= 8'h00;
         wake_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         hdr_reg <= hdr_next;
         hidx_reg <= hidx_next;
         eidx_reg <= eidx_next;
         to_host_reg <= to_host_next;
         to_stk_reg <= to_stk_next;
         od_reg <= od_next;
         hv_reg <= hv_next;
         sv_reg <= sv_next;
         osof_reg <= osof_next;
         oeof_reg <= oeof_next;
         habt_reg <= habt_next;
         sabt_reg <= sabt_next;
         win_reg <= win_next;
         pos_reg <= pos_next;
         wake_reg <= wake_next;
      end
   end

   // Upstream path: one output stage, stalls the host when the cable side stalls
   logic cvld_reg, cvld_next;
   logic [7:0] cdat_reg, cdat_next;
   logic csof_reg, csof_next;
   logic ceof_reg, ceof_next;
   logic cabt_reg, cabt_next;
   logic inf_reg, inf_next;
   logic fwd_reg, fwd_next;
   logic ferr_reg, ferr_next;
   logic up_acc;
   logic fwd_new;

   assign up_ready_o = !cvld_reg || cab_ready_i;
   assign up_acc = up_valid_i && up_ready_o;
   assign fwd_new = up_pdu_i && up_en_reg;

   always_comb begin
      cvld_next = cab_ready_i ? 1'b0 : cvld_reg;
      cdat_next = cdat_reg;
      csof_next = csof_reg;
      ceof_next = ceof_reg;
      cabt_next = cabt_reg;
      inf_next = inf_reg;
      fwd_next = fwd_reg;
      ferr_next = dn_err;
      if (up_acc) begin
         cvld_next = 1'b0;
         cdat_next = up_data_i;
         csof_next = 1'b0;
         ceof_next = up_eof_i;
         cabt_next = 1'b0;
         if (up_sof_i) begin
            ferr_next = dn_err || inf_reg; // R14
            cabt_next = inf_reg && fwd_reg; // R14
            cvld_next = fwd_new || (inf_reg && fwd_reg); // R13
            csof_next = fwd_new; // R13
            ceof_next = up_eof_i && fwd_new;
            fwd_next = fwd_new; // R13
            inf_next = !up_eof_i;
         end else if (inf_reg) begin
            cvld_next = fwd_reg; // R13 R19
            if (up_eof_i) begin
               inf_next = 1'b0;
            end
         end else begin
            ferr_next = 1'b1; // R14
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cvld_reg <= 1'b0;
         cdat_reg <= 8'h00;
         csof_reg <= 1'b0;
         ceof_reg <= 1'b0;
         cabt_reg <= 1'b0;
         inf_reg <= 1'b0;
         fwd_reg <= 1'b0;
         ferr_reg <= 1'b0;
      end else begin
         cvld_reg <= cvld_next;
         cdat_reg <= cdat_next;
         csof_reg <= csof_next;
         ceof_reg <= ceof_next;
         cabt_reg <= cabt_next;
         inf_reg <= inf_next;
         fwd_reg <= fwd_next;
         ferr_reg <= ferr_next;
      end
   end

   assign host_valid_o = hv_reg;
   assign host_data_o = od_reg;
   assign host_sof_o = osof_reg && hv_reg;
   assign host_eof_o = oeof_reg && hv_reg;
   assign host_abort_o = habt_reg;
   assign stk_valid_o = sv_reg;
   assign stk_data_o = od_reg;
   assign stk_sof_o = osof_reg && sv_reg;
   assign stk_eof_o = oeof_reg && sv_reg;
   assign stk_abort_o = sabt_reg;
   assign cab_valid_o = cvld_reg;
   assign cab_data_o = cdat_reg;
   assign cab_sof_o = csof_reg;
   assign cab_eof_o = ceof_reg;
   assign cab_abort_o = cabt_reg;
   assign resp_valid_o = resp_vld_reg;
   assign resp_data_o = resp_data_reg;
   assign resp_err_o = resp_err_reg;
   // Open-drain wake line: only ever pulls low
   assign pme_out_o = 1'b0; // R12
   assign pme_oe_n_o = !wake_reg; // R12
   assign frm_err_o = ferr_reg;

   a_emit_six_bytes: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
      $rose(state_reg == ST_EMIT) |-> (!dn_ready_o)[*6] ##1 (state_reg == ST_BODY))
      else $error("replay of address bytes not six cycles");
   a_modem_never_host: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
      (state_reg == ST_EMIT && to_host_reg) |-> (hdr_reg != modem_reg))
      else $error("own-address frame sent to host");
   a_unicast_host_only: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
      (state_reg == ST_EMIT && to_host_reg && !hdr_reg[GROUP_BIT]) |-> (hdr_reg == host_reg))
      else $error("foreign unicast sent to host");
   a_bcast_to_host: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
      (state_reg == ST_EMIT && eidx_reg == 3'h0 && hdr_reg == BCAST_ADDR) |-> ##1 host_valid_o && host_sof_o)
      else $error("broadcast not delivered to host");
   a_own_to_stack: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
      (state_reg == ST_EMIT && hdr_reg == modem_reg && !hdr_reg[GROUP_BIT]) |-> to_stk_reg && !to_host_reg)
      else $error("own-address frame not steered to stack");
   a_host_addr_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
      (cmd_valid_i && cmd_op_i == CMD_RD_HOST) |=> resp_valid_o && !resp_err_o && resp_data_o == $past(host_reg))
      else $error("host address readback wrong");
   a_wake_needs_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
      $fell(pme_oe_n_o) |-> $past(sleep_reg) && $past(hv_next))
      else $error("wake asserted without sleep and host byte");
   a_up_forward: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
      (up_acc && up_sof_i && fwd_new) |=> cab_valid_o && cab_sof_o && cab_data_o == $past(up_data_i))
      else $error("outbound data unit start not forwarded");
   a_up_block: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
      (up_acc && up_sof_i && !fwd_new && !inf_reg) |=> !cab_valid_o)
      else $error("unmarked or disabled frame forwarded");
   a_runt_dropped: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
      (state_reg == ST_HDR && dn_acc && !dn_sof_i && dn_eof_i) |=> (state_reg == ST_IDLE) && !host_valid_o)
      else $error("short frame not dropped");
endmodule
`default_nettype wire

//--- hdl/mhf_pkg.sv
// Constants and types shared by the modem host frame forwarder
// Behaviour
// R1 - Every station address is 48 bits wide
// R2 - Hold modem address and host address separately
// R3 - Frames for host address go to host
// R4 - Other unicast frames never reach the host
// R5 - Own-address frames go to internal stack
// R6 - Own-address frames never go to host
// R7 - Broadcast frames go to the host
// R8 - Multicast to host only via operator filters
// R9 - Host programs extra restrictive multicast filters
// R10 - Host cannot read or change operator filters
// R11 - LLC TEST/XID for host passed unanswered
// R12 - Sleeping host woken by pattern match, PME
// R13 - Outbound host data units forwarded when enabled
// R14 - Framing: sync, frame boundaries, stream error recovery
// R15 - Management messages query and configure the modem
// R16 - Host can read back its address
// R17 - Wake patterns exchanged via management messages
// R18 - Address forwarding as bridge, no spanning tree
// R19 - Both frame formats passed through unaltered
// R20 - No promiscuous forward-all mode exists
// R21 - Classify destination unicast, multicast or broadcast
`default_nettype none
package mhf_pkg;
   localparam int ADDR_W = 48;
   localparam int ADDR_BYTES = 6;
   localparam logic [2:0] HDR_LAST = 3'h5;
   localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
   localparam int GROUP_BIT = 40;
   localparam int FILT_N_DEF = 4;
   localparam logic [47:0] ADDR_RST = 48'h0000_0000_0000;
   localparam logic [31:0] WK_PAT_RST = 32'h0000_0000;
   localparam logic [7:0] WK_OFF_RST = 8'h00;
   localparam logic [7:0] WK_SPAN = 8'h03;
   localparam logic [7:0] POS_MAX = 8'hFF;
   localparam logic [7:0] WK_PAD = 8'h00;
   localparam logic [2:0] CMD_RD_HOST = 3'h0;
   localparam logic [2:0] CMD_SET_MC = 3'h1;
   localparam logic [2:0] CMD_CLR_MC = 3'h2;
   localparam logic [2:0] CMD_MC_EN = 3'h3;
   localparam logic [2:0] CMD_SET_WAKE = 3'h4;
   localparam logic [2:0] CMD_RD_WAKE = 3'h5;
   localparam logic [2:0] CMD_SLEEP = 3'h6;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_HDR = 5'b00010,
      ST_EMIT = 5'b00100,
      ST_BODY = 5'b01000,
      ST_DROP = 5'b10000
   } mhf_state_e;
endpackage
`default_nettype wire
